//--- verilog/tds_pkg.sv
// Constants, types and field decoding shared by the transmit data descriptor engine
`default_nettype none
package tds_pkg;
  // Register offsets
  localparam logic [7:0] TDS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] TDS_MAXPKT_OFS = 8'h04;
  localparam logic [7:0] TDS_STOFS_OFS  = 8'h08;
  localparam logic [7:0] TDS_STAT_OFS   = 8'h0C;
  localparam logic [7:0] TDS_COUNT_OFS  = 8'h10;
  localparam logic [7:0] TDS_TSLO_OFS   = 8'h14;
  localparam logic [7:0] TDS_TSHI_OFS   = 8'h18;
  // Reset values
  localparam logic [15:0] TDS_MAXPKT_RST = 16'h2600;
  localparam logic [15:0] TDS_STOFS_RST  = 16'h0000;
  // Control and status bit positions
  localparam int TDS_CTRL_STAMP = 0;
  localparam int TDS_CTRL_PAD   = 1;
  localparam int TDS_STAT_BUSY  = 0;
  localparam int TDS_STAT_BAD   = 1;
  localparam int TDS_STAT_BIG   = 2;
  // Descriptor upper word layout
  localparam int TDS_LEN_LSB  = 0;
  localparam int TDS_REQ_LSB  = 18;
  localparam int TDS_KIND_LSB = 20;
  localparam int TDS_CMD_LSB  = 24;
  localparam int TDS_CTX_LSB  = 36;
  localparam int TDS_OPT_LSB  = 40;
  localparam int TDS_PAY_LSB  = 46;
  localparam logic [3:0] TDS_KIND_DATA = 4'h3;
  // Command byte bits
  localparam int TDS_CMD_SEG  = 7;
  localparam int TDS_CMD_TAG  = 6;
  localparam int TDS_CMD_EXT  = 5;
  localparam int TDS_CMD_RS   = 3;
  localparam int TDS_CMD_FCS  = 1;
  localparam int TDS_CMD_LAST = 0;
  // Offload option and stamp request bits
  localparam int TDS_OPT_L4 = 1;
  localparam int TDS_OPT_IP = 0;
  localparam int TDS_REQ_ONE = 0;
  localparam int TDS_REQ_TWO = 1;
  // Write-back layout
  localparam int TDS_WB_DONE = 0;
  localparam int TDS_WB_SVAL = 1;
  localparam int TDS_WB_FLAG_LSB = 32;
  localparam int TDS_HIGH_BITS = 10;
  // Transport kind codes
  localparam logic [1:0] TDS_L4_UDP  = 2'b00;
  localparam logic [1:0] TDS_L4_TCP  = 2'b01;
  localparam logic [1:0] TDS_L4_SCTP = 2'b10;

  typedef enum logic [2:0] {
    TDS_ST_IDLE  = 3'b001,
    TDS_ST_FETCH = 3'b010,
    TDS_ST_FIN   = 3'b100
  } tds_state_e;

  // Descriptor is an advanced data descriptor
  function automatic logic tds_is_data(input logic [63:0] hi);
    tds_is_data = (hi[TDS_KIND_LSB +: 4] == TDS_KIND_DATA) && hi[TDS_CMD_LSB + TDS_CMD_EXT];
  endfunction
endpackage
`default_nettype wire

//--- verilog/tds_decode.sv
// Field decoder for the descriptor upper word and the context transport kind
`timescale 1ns/1ps
`default_nettype none
module tds_decode
  import tds_pkg::*;
(
  input  wire logic [63:0] desc_hi,
  input  wire logic [1:0]  transport_kind,
  output logic [15:0]      buffer_length,
  output logic [7:0]       command_field,
  output logic             one_step,
  output logic             two_step,
  output logic [2:0]       context_select,
  output logic             l4_sum,
  output logic             ip_sum,
  output logic [17:0]      payload_size,
  output logic [2:0]       kind_onehot
);
  // Reserved bits reach no output except command_field, which carries the whole command byte
  assign buffer_length  = desc_hi[TDS_LEN_LSB +: 16];
  assign command_field  = desc_hi[TDS_CMD_LSB +: 8];
  assign context_select = desc_hi[TDS_CTX_LSB +: 3];
  assign l4_sum         = desc_hi[TDS_OPT_LSB + TDS_OPT_L4];
  assign ip_sum         = desc_hi[TDS_OPT_LSB + TDS_OPT_IP];
  assign payload_size   = desc_hi[TDS_PAY_LSB +: 18];
  // Both stamp requests together is treated as neither
  assign one_step = desc_hi[TDS_REQ_LSB + TDS_REQ_ONE] & ~desc_hi[TDS_REQ_LSB + TDS_REQ_TWO];
  assign two_step = desc_hi[TDS_REQ_LSB + TDS_REQ_TWO] & ~desc_hi[TDS_REQ_LSB + TDS_REQ_ONE];
  // Order is sctp, tcp, udp; reserved code gives none
  assign kind_onehot = {transport_kind == TDS_L4_SCTP,
                        transport_kind == TDS_L4_TCP,
                        transport_kind == TDS_L4_UDP};
endmodule
`default_nettype wire

//--- verilog/tds_wb_format.sv
// Builds the two write-back words from status and the current time
`timescale 1ns/1ps
`default_nettype none
module tds_wb_format
  import tds_pkg::*;
(
  input  wire logic [31:0] time_low_word,
  input  wire logic [31:0] time_high_word,
  input  wire logic        stamp_enable,
  output logic [63:0]      wb_lo,
  output logic [63:0]      wb_hi
);
  logic [3:0] flags;
  // Stamp is zero when disabled, a defined stand-in for undefined
  assign wb_lo = stamp_enable ?
                 {22'h0, time_high_word[TDS_HIGH_BITS-1:0], time_low_word} : 64'h0;
  assign flags = {2'b00, stamp_enable, 1'b1};
  assign wb_hi = {28'h0, flags, 32'h0};
endmodule
`default_nettype wire

//--- verilog/tds_engine.sv
// Transmit data descriptor engine: decode, buffer fetch, packet info and write-back
`timescale 1ns/1ps
`default_nettype none
module tds_engine
  import tds_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        desc_valid,
  input  wire logic [63:0] desc_addr,
  input  wire logic [63:0] desc_hi,
  output logic             desc_ready,
  output logic             fetch_req,
  output logic [63:0]      fetch_addr,
  output logic [15:0]      fetch_len,
  input  wire logic        fetch_done,
  input  wire logic [1:0]  ctx_transport_kind,
  output logic             pkt_start,
  output logic             pkt_end,
  output logic             pkt_seg,
  output logic             pkt_tag,
  output logic             pkt_fcs,
  output logic             pkt_l4_sum,
  output logic             pkt_ip_sum,
  output logic [2:0]       pkt_kind,
  output logic [2:0]       pkt_ctx,
  output logic             pkt_ctx_used,
  output logic [17:0]      pkt_payload,
  output logic             pkt_one_step,
  output logic             pkt_two_step,
  output logic             pkt_short_pad,
  output logic [15:0]      stamp_insert_offset,
  input  wire logic [31:0] time_low_word,
  input  wire logic [31:0] time_high_word,
  input  wire logic        tx_stamp_event,
  output logic             wb_valid,
  output logic [63:0]      wb_lo,
  output logic [63:0]      wb_hi
);
  import tds_pkg::*;

  tds_state_e  state_reg;
  tds_state_e  state_next;
  logic [1:0]  ctrl_reg;
  logic [15:0] max_tx_packet_reg;
  logic [2:0]  stat_reg;
  logic [31:0] count_reg;
  logic [63:0] tx_stamp_regs;
  logic        two_pend_reg;
  logic        in_pkt_reg;
  logic        rs_reg;
  logic        last_reg;
  logic [17:0] bytes_reg;
  logic [31:0] rdata_next;

  // Decoded descriptor fields
  logic [15:0] d_len;
  logic [7:0]  d_cmd;
  logic        d_one;
  logic        d_two;
  logic [2:0]  d_ctx;
  logic        d_l4;
  logic        d_ip;
  logic [17:0] d_pay;
  logic [2:0]  d_kind;
  logic [63:0] f_lo;
  logic [63:0] f_hi;

  tds_decode u_dec (
    .desc_hi        (desc_hi),
    .transport_kind (ctx_transport_kind),
    .buffer_length  (d_len),
    .command_field  (d_cmd),
    .one_step       (d_one),
    .two_step       (d_two),
    .context_select (d_ctx),
    .l4_sum         (d_l4),
    .ip_sum         (d_ip),
    .payload_size   (d_pay),
    .kind_onehot    (d_kind)
  );

  tds_wb_format u_wb (
    .time_low_word  (time_low_word),
    .time_high_word (time_high_word),
    .stamp_enable   (ctrl_reg[TDS_CTRL_STAMP]),
    .wb_lo          (f_lo),
    .wb_hi          (f_hi)
  );

  // Descriptor acceptance and classification
  wire take      = desc_valid & desc_ready;
  wire good      = tds_is_data(desc_hi);
  wire bad_take  = take & ~good;
  wire good_take = take & good;
  wire first     = good_take & ~in_pkt_reg;
  wire offload   = d_cmd[TDS_CMD_SEG] | d_cmd[TDS_CMD_TAG] | d_l4 | d_ip;
  wire [17:0] bytes_sum = (first ? 18'h0 : bytes_reg) + {2'b00, d_len};
  wire too_big   = good_take & (bytes_sum > {2'b00, max_tx_packet_reg});
  wire fin_now   = (state_reg == TDS_ST_FIN);

  // Register port decode
  wire wr_ctrl  = reg_wr & (reg_addr == TDS_CTRL_OFS);
  wire wr_max   = reg_wr & (reg_addr == TDS_MAXPKT_OFS);
  wire wr_stofs = reg_wr & (reg_addr == TDS_STOFS_OFS);
  wire wr_stat  = reg_wr & (reg_addr == TDS_STAT_OFS);
  wire [2:0] stat_set = {too_big, bad_take, 1'b0};
  wire [2:0] stat_clr = wr_stat ? reg_wdata[2:0] : 3'b000;

  // Next state: zero length skips the fetch entirely
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TDS_ST_IDLE:
      begin
        if (good_take)
          state_next = (d_len != 16'h0000) ? TDS_ST_FETCH : TDS_ST_FIN;
      end
      TDS_ST_FETCH:
      begin
        if (fetch_done)
          state_next = TDS_ST_FIN;
      end
      TDS_ST_FIN:
        state_next = TDS_ST_IDLE;
      default:
        state_next = TDS_ST_IDLE;
    endcase
  end

  // Read data mux; unmapped offsets read zero
  always_comb
  begin
    case (reg_addr)
      TDS_CTRL_OFS:   rdata_next = {30'h0, ctrl_reg};
      TDS_MAXPKT_OFS: rdata_next = {16'h0, max_tx_packet_reg};
      TDS_STOFS_OFS:  rdata_next = {16'h0, stamp_insert_offset};
      TDS_STAT_OFS:   rdata_next = {29'h0, stat_reg[2:1], state_reg != TDS_ST_IDLE};
      TDS_COUNT_OFS:  rdata_next = count_reg;
      TDS_TSLO_OFS:   rdata_next = tx_stamp_regs[31:0];
      TDS_TSHI_OFS:   rdata_next = tx_stamp_regs[63:32];
      default:        rdata_next = 32'h0000_0000;
    endcase
  end

  // Register port flops; sticky status bits favour a new event over a clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_reg            <= 2'b00;
      max_tx_packet_reg   <= TDS_MAXPKT_RST;
      stamp_insert_offset <= TDS_STOFS_RST;
      stat_reg            <= 3'b000;
      reg_rdata           <= 32'h0000_0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= reg_wdata[1:0];
      if (wr_max)
        max_tx_packet_reg <= reg_wdata[15:0];
      if (wr_stofs)
        stamp_insert_offset <= reg_wdata[15:0];
      stat_reg  <= (stat_reg & ~stat_clr) | stat_set;
      reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  // Two-step stamp: armed by a packet, caught on the transmit event
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      two_pend_reg  <= 1'b0;
      tx_stamp_regs <= 64'h0;
    end
    else
    begin
      if (tx_stamp_event & two_pend_reg)
        tx_stamp_regs <= {time_high_word, time_low_word};
      if (first & d_two)
        two_pend_reg <= 1'b1;
      else if (tx_stamp_event)
        two_pend_reg <= 1'b0;
    end
  end

  // Main sequencer and per-buffer bookkeeping
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg  <= TDS_ST_IDLE;
      desc_ready <= 1'b1;
      in_pkt_reg <= 1'b0;
      rs_reg     <= 1'b0;
      last_reg   <= 1'b0;
      bytes_reg  <= 18'h0;
      count_reg  <= 32'h0000_0000;
      fetch_req  <= 1'b0;
      fetch_addr <= 64'h0;
      fetch_len  <= 16'h0000;
    end
    else
    begin
      state_reg  <= state_next;
      desc_ready <= (state_next == TDS_ST_IDLE);
      fetch_req  <= good_take & (d_len != 16'h0000);
      if (good_take)
      begin
        // Per-buffer fields come from every accepted data descriptor
        fetch_addr <= desc_addr;
        fetch_len  <= d_len;
        rs_reg     <= d_cmd[TDS_CMD_RS];
        last_reg   <= d_cmd[TDS_CMD_LAST];
        bytes_reg  <= bytes_sum;
        in_pkt_reg <= 1'b1;
        count_reg  <= count_reg + 32'h0000_0001;
      end
      else if (fin_now & last_reg)
        in_pkt_reg <= 1'b0;
    end
  end

  // Packet-wide fields, latched from the first descriptor only
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pkt_start     <= 1'b0;
      pkt_seg       <= 1'b0;
      pkt_tag       <= 1'b0;
      pkt_fcs       <= 1'b0;
      pkt_l4_sum    <= 1'b0;
      pkt_ip_sum    <= 1'b0;
      pkt_kind      <= 3'b000;
      pkt_ctx       <= 3'b000;
      pkt_ctx_used  <= 1'b0;
      pkt_payload   <= 18'h0;
      pkt_one_step  <= 1'b0;
      pkt_two_step  <= 1'b0;
      pkt_short_pad <= 1'b0;
    end
    else
    begin
      pkt_start <= first;
      if (first)
      begin
        pkt_seg       <= d_cmd[TDS_CMD_SEG];
        pkt_tag       <= d_cmd[TDS_CMD_TAG];
        pkt_fcs       <= d_cmd[TDS_CMD_FCS];
        pkt_l4_sum    <= d_l4;
        pkt_ip_sum    <= d_ip;
        pkt_kind      <= d_kind;
        pkt_ctx       <= offload ? d_ctx : 3'b000;
        pkt_ctx_used  <= offload;
        pkt_payload   <= d_pay;
        pkt_one_step  <= d_one;
        pkt_two_step  <= d_two;
        pkt_short_pad <= ctrl_reg[TDS_CTRL_PAD];
      end
    end
  end

  // Completion: done only after the buffer fetch has finished
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pkt_end  <= 1'b0;
      wb_valid <= 1'b0;
      wb_lo    <= 64'h0;
      wb_hi    <= 64'h0;
    end
    else
    begin
      pkt_end  <= fin_now & last_reg;
      wb_valid <= fin_now & rs_reg;
      if (fin_now & rs_reg)
      begin
        wb_lo <= f_lo;
        wb_hi <= f_hi;
      end
    end
  end

  // Checks kept beside the logic they watch
  a_zero_no_fetch: assert property (@(posedge clk) disable iff (reset)
    good_take && d_len == 16'h0000 |=> !fetch_req ##1 !fetch_req)
    else $error("zero length buffer was fetched");
  a_fetch_len_ok: assert property (@(posedge clk) disable iff (reset)
    good_take && d_len != 16'h0000 |=> fetch_req && fetch_len == $past(d_len))
    else $error("fetch request missing or wrong length");
  a_bad_kind_drop: assert property (@(posedge clk) disable iff (reset)
    bad_take |=> !fetch_req && !pkt_start && stat_reg[TDS_STAT_BAD])
    else $error("non data descriptor not dropped");
  a_stamp_layout: assert property (@(posedge clk) disable iff (reset)
    wb_valid && wb_hi[TDS_WB_FLAG_LSB + TDS_WB_SVAL] |->
      wb_lo[63:42] == 22'h0 && wb_lo[31:0] == $past(time_low_word))
    else $error("write-back stamp layout wrong");
  a_stamp_flag: assert property (@(posedge clk) disable iff (reset)
    fin_now && rs_reg |=> wb_valid &&
      wb_hi[TDS_WB_FLAG_LSB + TDS_WB_SVAL] == $past(ctrl_reg[TDS_CTRL_STAMP]))
    else $error("stamp valid flag does not follow enable");
  a_wb_flags: assert property (@(posedge clk) disable iff (reset)
    wb_valid |-> wb_hi[TDS_WB_FLAG_LSB + TDS_WB_DONE] && wb_hi[63:36] == 28'h0
      && wb_hi[31:0] == 32'h0)
    else $error("write-back flags malformed");
  a_done_after_fetch: assert property (@(posedge clk) disable iff (reset)
    state_reg == TDS_ST_FETCH && !fetch_done |=> !wb_valid && state_reg == TDS_ST_FETCH)
    else $error("done written before buffer fetched");
  a_step_exclusive: assert property (@(posedge clk) disable iff (reset)
    !(pkt_one_step && pkt_two_step))
    else $error("both stamp modes requested");
  a_end_on_last: assert property (@(posedge clk) disable iff (reset)
    pkt_end |-> $past(last_reg, 1) && $past(fin_now, 1))
    else $error("packet ended without last buffer");
  a_first_only: assert property (@(posedge clk) disable iff (reset)
    good_take && in_pkt_reg |=> $stable(pkt_seg) && $stable(pkt_payload))
    else $error("later descriptor changed packet fields");
  a_big_flag: assert property (@(posedge clk) disable iff (reset)
    too_big |=> stat_reg[TDS_STAT_BIG])
    else $error("oversize packet not flagged");
endmodule
`default_nettype wire

//--- testbench/tds_host_mem.sv
// Host memory model that answers each buffer fetch after a chosen latency
`timescale 1ns/1ps
`default_nettype none
module tds_host_mem
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       fetch_req,
  input  wire logic [3:0] latency,
  output var  logic       fetch_done
);
  logic [3:0] cnt_reg;

  // One completion per request, the whole buffer at once; latency must be 1 or more
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_reg    <= 4'h0;
      fetch_done <= 1'b0;
    end
    else
    begin
      fetch_done <= (cnt_reg == 4'h1);
      if (fetch_req)
        cnt_reg <= latency;
      else if (cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking testbench of the transmit data descriptor engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tds_pkg::*;
  localparam logic [7:0] C_LAST = 8'h01, C_FCS = 8'h02, C_RS = 8'h08;
  localparam logic [7:0] C_EXT  = 8'h20, C_TAG = 8'h40, C_SEG = 8'h80;
  logic        clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        desc_valid = 1'b0, tx_stamp_event = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, tl = 32'h1234_5678, th = 32'hFFFF_F6A5;
  logic [63:0] desc_addr = 64'h0, desc_hi = 64'h0;
  logic [1:0]  ctx_transport_kind = 2'b00;
  logic [3:0]  latency = 4'h1;
  logic [31:0] reg_rdata, rdv;
  logic        desc_ready, fetch_req, fetch_done, pkt_start, pkt_end, pkt_seg, pkt_tag;
  logic        pkt_fcs, pkt_l4_sum, pkt_ip_sum, pkt_ctx_used, pkt_one_step, pkt_two_step;
  logic        pkt_short_pad, wb_valid, got_fetch, got_end, got_start;
  logic [63:0] fetch_addr, wb_lo, wb_hi, wbl, wbh;
  logic [15:0] fetch_len, stamp_insert_offset;
  logic [2:0]  pkt_kind, pkt_ctx;
  logic [17:0] pkt_payload;
  int          err_count = 0, tests_run = 0, nd, nw;

  tds_engine u_tds_engine (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .desc_valid, .desc_addr, .desc_hi, .desc_ready, .fetch_req, .fetch_addr, .fetch_len,
    .fetch_done, .ctx_transport_kind, .pkt_start, .pkt_end, .pkt_seg, .pkt_tag, .pkt_fcs,
    .pkt_l4_sum, .pkt_ip_sum, .pkt_kind, .pkt_ctx, .pkt_ctx_used, .pkt_payload, .pkt_one_step,
    .pkt_two_step, .pkt_short_pad, .stamp_insert_offset, .time_low_word(tl),
    .time_high_word(th), .tx_stamp_event, .wb_valid, .wb_lo, .wb_hi);
  tds_host_mem u_tds_host_mem (.clk, .reset, .fetch_req, .latency, .fetch_done);

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Reserved descriptor bits outside the option field are driven to ones so that any use of them shows
  function automatic logic [63:0] mk(input logic [15:0] len, input logic [1:0] req,
    input logic [3:0] kind, input logic [7:0] cmd, input logic [2:0] ctx, input logic [5:0] opt);
    mk = {18'h2_0001, opt, 1'b1, ctx, 4'hF, cmd | 8'h14, kind, req, 2'b11, len};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
  endtask

  // Offers one descriptor and records the pulses that follow until the engine is idle again;
  // index n is the n-th edge from the take, so one-cycle pulses right after it are seen too
  task automatic send(input logic [63:0] hi, input logic [3:0] lat);
    got_fetch = 1'b0;
    got_end = 1'b0;
    got_start = 1'b0;
    nd = 0;
    nw = 0;
    @(posedge clk);
    latency    <= lat;
    desc_valid <= 1'b1;
    desc_hi    <= hi;
    desc_addr  <= desc_addr + 64'h0000_0000_0000_1040;
    @(posedge clk);
    desc_valid <= 1'b0;
    for (int n = 1; n < 40; n++)
    begin
      if (n > 1)
        @(posedge clk);
      #1;
      if (fetch_req === 1'b1) got_fetch = 1'b1;
      if (pkt_start === 1'b1) got_start = 1'b1;
      if (fetch_done === 1'b1) nd = n;
      if (pkt_end === 1'b1) got_end = 1'b1;
      if (wb_valid === 1'b1) nw = n;
      if (wb_valid === 1'b1) {wbl, wbh} = {wb_lo, wb_hi};
      if (n > 1 && desc_ready === 1'b1) break;
    end
  endtask

  task automatic t_regs();
    rd(TDS_MAXPKT_OFS);
    chk("max_pkt", rdv, 32'h0000_2600);
    rd(8'h40);
    chk("unmapped", rdv, 32'h0000_0000);
    wr(TDS_STOFS_OFS, 32'h0000_0036);
    rd(TDS_STOFS_OFS);
    chk("insert_ofs", {rdv, stamp_insert_offset}, 48'h0000_0036_0036);
  endtask

  // Stamp off with a prompt fetch, then stamp on with a slow one; padding is off here,
  // so the packet is kept at 64 bytes
  task automatic t_stamp();
    for (int en = 0; en < 2; en++)
    begin
      wr(TDS_CTRL_OFS, 32'(en));
      send(mk(16'h0040, 2'b00, 4'h3, C_EXT | C_RS | C_LAST | C_FCS, 3'h0, 6'h00), 4'(1 + 5 * en));
      chk("fetch_len", fetch_len, 16'h0040);
      chk("fetch_addr", fetch_addr, desc_addr);
      chk("done_gap", 64'(nw - nd), 64'h2);
      chk("wb_hi", wbh, {28'h0, 2'b00, en[0], 1'b1, 32'h0});
      chk("wb_lo", wbl, en[0] ? {22'h0, th[9:0], tl} : 64'h0);
    end
  endtask

  // Two-buffer segmented packet; padding and trailer on as software must
  task automatic t_multi();
    wr(TDS_CTRL_OFS, 32'h0000_0002);
    ctx_transport_kind <= 2'b01; // TCP transport kind with both sums
    send(mk(16'h0010, 2'b01, 4'h3, C_SEG | C_TAG | C_EXT | C_FCS, 3'h5, 6'h3F), 4'h3);
    chk("mid_end", got_end, 1'b0);
    chk("start", got_start, 1'b1);
    chk("flags", {pkt_seg, pkt_tag, pkt_fcs, pkt_l4_sum, pkt_ip_sum, pkt_one_step, pkt_short_pad},
        7'h7F);
    chk("ctx", {pkt_ctx_used, pkt_ctx, pkt_kind}, 7'h6A);
    chk("payload", pkt_payload, 18'h2_0001);
    ctx_transport_kind <= 2'b00;
    send(mk(16'h0004, 2'b10, 4'h3, C_EXT | C_RS | C_LAST, 3'h2, 6'h00), 4'h1);
    chk("end", got_end, 1'b1);
    chk("start2", got_start, 1'b0);
    chk("fetch_len2", fetch_len, 16'h0004);
    chk("kept", {pkt_seg, pkt_tag, pkt_fcs, pkt_l4_sum, pkt_ip_sum, pkt_one_step, pkt_two_step,
        pkt_ctx, pkt_kind}, 13'h1FAA);
  endtask

  task automatic t_kinds();
    for (int k = 0; k < 4; k++)
    begin
      ctx_transport_kind <= 2'(k);
      send(mk(16'h0011, 2'b00, 4'h3, C_EXT | C_FCS | C_LAST, 3'h1, 6'h02), 4'h2);
      chk("l4_kind", pkt_kind, (k == 3) ? 3'b000 : 3'(1 << k));
    end
    send(mk(16'h0011, 2'b00, 4'h3, C_EXT | C_FCS | C_LAST, 3'h6, 6'h3C), 4'h2);
    chk("no_ctx", {pkt_ctx_used, pkt_ctx, pkt_l4_sum, pkt_ip_sum}, 6'h00);
  endtask

  task automatic t_req();
    for (int r = 0; r < 5; r++)
    begin
      send(mk(16'h0011, 2'(r), 4'h3, C_EXT | C_FCS | C_LAST, 3'h0, 6'h00), 4'h1);
      chk("stamp_req", {pkt_two_step, pkt_one_step}, (r == 3) ? 2'b00 : 2'(r));
    end
    @(posedge clk);
    tx_stamp_event <= 1'b1;
    @(posedge clk);
    tx_stamp_event <= 1'b0;
    rd(TDS_TSLO_OFS);
    chk("stamp_lo", rdv, tl);
    rd(TDS_TSHI_OFS);
    chk("stamp_hi", rdv, th);
  endtask

  // Zero length last buffer, wrong kind, legacy format, then an oversize packet;
  // the empty buffer closes a 32-byte packet so that software keeps its minimum length
  task automatic t_odd();
    send(mk(16'h0020, 2'b00, 4'h3, C_EXT | C_FCS, 3'h0, 6'h00), 4'h1);
    send(mk(16'h0000, 2'b00, 4'h3, C_EXT | C_RS | C_LAST | C_FCS, 3'h0, 6'h00), 4'h1);
    chk("zero_len", {got_fetch, 8'(nw)}, 9'h002);
    send(mk(16'h0008, 2'b00, 4'h2, C_EXT | C_RS | C_LAST, 3'h0, 6'h00), 4'h1);
    chk("bad_kind", {got_fetch, got_end, nw != 0}, 3'b000);
    send(mk(16'h0008, 2'b00, 4'h3, C_RS | C_LAST, 3'h0, 6'h00), 4'h1);
    chk("legacy", {got_fetch, got_end, nw != 0}, 3'b000);
    rd(TDS_STAT_OFS);
    chk("bad_flag", rdv[2:1], 2'b01);
    wr(TDS_STAT_OFS, 32'h0000_0002);
    wr(TDS_MAXPKT_OFS, 32'h0000_0010);
    send(mk(16'h0020, 2'b00, 4'h3, C_EXT | C_FCS | C_LAST, 3'h0, 6'h00), 4'h1);
    rd(TDS_STAT_OFS);
    chk("oversize", rdv[2:1], 2'b10);
  endtask

  // Main sequence after eight cycles of reset
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_stamp();
    t_multi();
    t_kinds();
    t_req();
    t_odd();
    end_sim();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #2_000_000;
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
